/* File: dv/lbam_monitor_tb.sv */
// Purpose: Self-checking bench for the leaky bucket activity monitor.
// Assumes: A short evaluation window set through the EVAL_CYCLES parameter.
// Notes:   Expected values follow from the register settings and WIN.
`timescale 1ns/1ns
module lbam_monitor_tb;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  // A short window keeps the run brief; the expected gaps and the saturation hold scale from it.
  localparam int unsigned WIN = 20;
  logic       clk_i;        // Core clock.
  logic       rst_i;        // Asynchronous reset.
  logic       fail_i;       // Monitored failure level.
  logic [7:0] addr_i;       // Register address.
  logic [7:0] wdata_i;      // Register write data.
  logic       we_i;         // Write strobe.
  logic       re_i;         // Read strobe.
  logic [7:0] rdata_o;      // Read data.
  logic [7:0] level_o;      // Bucket count.
  logic       alarm_o;      // Inactivity alarm.
  logic       irq_o;        // Interrupt level.
  int         fails;        // Mismatches seen.
  int         comparisons;  // Compares made.
  logic [7:0] rd_v;         // Last value read.
  int         n;            // Measured gap in clocks.

  lbam_monitor #(.EVAL_CYCLES(WIN)) i_lbam_monitor (
    .clk_i(clk_i), .rst_i(rst_i), .fail_i(fail_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o),
    .level_o(level_o), .alarm_o(alarm_o), .irq_o(irq_o));

  // ---------------------------------------------------------------
  // Clock and helpers
  // ---------------------------------------------------------------
  // The 40 ns period gives the 25 MHz core rate.
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  // Prints the counts and the verdict, then stops.
  task automatic summarize();
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Compares one value against its expectation.
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One-cycle write strobe beside address and data.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    we_i    <= 1'b1;
    @(posedge clk_i);
    we_i    <= 1'b0;
    #1;
  endtask

  // One-cycle read strobe; the data stand in the following cycle only.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    re_i   <= 1'b1;
    @(posedge clk_i);
    re_i   <= 1'b0;
    #1;
    d = rdata_o;
  endtask

  // Waits a bounded time for the count to reach a value.
  task automatic wait_lvl(input logic [7:0] e);
    int i;
    for (i = 0; i < 400; i++) begin
      @(posedge clk_i);
      #1;
      if (level_o === e) break;
    end
    if (i == 400) begin
      fails++;
      summarize();
    end
  endtask

  // Counts clocks until the count moves; a stuck count ends the run.
  task automatic gap(output int c);
    logic [7:0] s;
    s = level_o;
    for (c = 1; c < 400; c++) begin
      @(posedge clk_i);
      #1;
      if (level_o !== s) break;
    end
    if (c == 400) begin
      fails++;
      summarize();
    end
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  // Register checks first, then fill, saturate and drain the bucket.
  initial begin
    fails = 0;
    comparisons = 0;
    rst_i = 1'b1;
    fail_i = 1'b0;
    addr_i = 8'h00;
    wdata_i = 8'h00;
    we_i = 1'b0;
    re_i = 1'b0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    chk(level_o, 8'h00);
    rd(lbam_pkg::ADDR_UPPER, rd_v);
    chk(rd_v, lbam_pkg::RST_UPPER);
    rd(lbam_pkg::ADDR_LOWER, rd_v);
    chk(rd_v, 8'h04);
    rd(lbam_pkg::ADDR_CEIL, rd_v);
    chk(rd_v, 8'h08);
    rd(8'h70, rd_v);
    chk(rd_v, 8'h00);
    wr(lbam_pkg::ADDR_LOWER, 8'hFF);
    rd(lbam_pkg::ADDR_LOWER, rd_v);
    chk(rd_v, 8'hFF);
    // Narrow thresholds so that raise and clear both occur quickly.
    wr(lbam_pkg::ADDR_LOWER, 8'h01);
    wr(lbam_pkg::ADDR_UPPER, 8'h03);
    wr(lbam_pkg::ADDR_CEIL, 8'h08);
    wr(lbam_pkg::ADDR_DECAY, 8'h00);
    wr(lbam_pkg::ADDR_MASK, 8'h03);
    @(posedge clk_i);
    fail_i <= 1'b1;
    // Each failing window adds one; the alarm waits for the upper level.
    for (int k = 1; k <= 3; k++) begin
      wait_lvl(k[7:0]);
      chk(alarm_o, k == 3);
    end
    chk(irq_o, 1'b1);
    wait_lvl(8'h08);
    repeat (3 * WIN) @(posedge clk_i);
    #1;
    chk(level_o, 8'h08);
    rd(lbam_pkg::ADDR_LEVEL, rd_v);
    chk(rd_v, 8'h88);
    // Masking hides the pending raise; clearing it removes it.
    wr(lbam_pkg::ADDR_MASK, 8'h00);
    chk(irq_o, 1'b0);
    wr(lbam_pkg::ADDR_STAT, 8'h03);
    rd(lbam_pkg::ADDR_STAT, rd_v);
    chk(rd_v, 8'h00);
    wr(lbam_pkg::ADDR_MASK, 8'h03);
    chk(irq_o, 1'b0);
    @(posedge clk_i);
    fail_i <= 1'b0;
    // The first gap after a change of setting may be partial, so skip it.
    gap(n);
    gap(n);
    chk(n, WIN);
    wr(lbam_pkg::ADDR_DECAY, 8'h01);
    gap(n);
    gap(n);
    chk(n, 2 * WIN);
    wr(lbam_pkg::ADDR_DECAY, 8'h02);
    gap(n);
    gap(n);
    chk(n, 4 * WIN);
    chk(level_o, 8'h02);
    chk(alarm_o, 1'b1);
    wr(lbam_pkg::ADDR_DECAY, 8'h03);
    gap(n);
    chk(alarm_o, 1'b0);
    chk(irq_o, 1'b1);
    // Measure the next gap straight from the leak; a register access
    // first would start the count late and shorten the figure.
    gap(n);
    chk(n, 8 * WIN);
    rd(lbam_pkg::ADDR_STAT, rd_v);
    chk(rd_v, 8'h02);
    wr(lbam_pkg::ADDR_STAT, 8'h03);
    chk(irq_o, 1'b0);
    // A zero ceiling is out of range and must be stored as one.
    wr(lbam_pkg::ADDR_CEIL, 8'h00);
    rd(lbam_pkg::ADDR_CEIL, rd_v);
    chk(rd_v, 8'h01);
    summarize();
  end
endmodule // lbam_monitor_tb

/* File: src/lbam_monitor.sv */
// Purpose: Leaky bucket activity alarm, configuration set two.
// Assumes: fail_i is an asynchronous level from the input checker.
// Notes:   Register port is byte-wide with one-cycle read latency.
//
// Overview of operation
// - Each 128 ms cycle, failure adds one.
// - Quiet cycles subtract one per decay period.
// - Alarm clears when count reaches lower threshold and is below upper threshold.
// - Count is capped at the programmed bucket ceiling at each window update.
// - Alarm raises when count reaches upper threshold.
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ns
module lbam_monitor #(
  parameter int unsigned EVAL_CYCLES = lbam_pkg::EVAL_CYCLES
) (
  // Clock and reset.
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Monitored reference condition.
  input  wire logic       fail_i,
  // Register port.
  input  wire logic [7:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       we_i,
  input  wire logic       re_i,
  output logic      [7:0] rdata_o,
  // Results.
  output logic      [7:0] level_o,
  output logic            alarm_o,
  output logic            irq_o
);

  // ---------------------------------------------------------------
  // Input synchroniser and window tick
  // ---------------------------------------------------------------
  logic       sync1_q;    // First stage, read only by second stage.
  logic       sync2_q;    // Safe synchronised failure level.
  logic       seen_q;     // Failure seen in this window.
  logic       seen_d;
  logic       tick;       // Window boundary pulse.

  lbam_tick #(
    .PERIOD (EVAL_CYCLES)
  ) u_tick (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .tick_o (tick)
  );

  // A failure anywhere in the window marks the whole window failed.
  always_comb begin
    if (tick) begin
      seen_d = 1'b0;
    end else begin
      seen_d = seen_q | sync2_q;
    end
  end

  // Register synchroniser and window flag.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      seen_q  <= 1'b0;
    end else begin
      sync1_q <= fail_i;
      sync2_q <= sync1_q;
      seen_q  <= seen_d;
    end
  end

  // Window verdict includes a failure on the final cycle.
  logic win_fail;
  assign win_fail = seen_q | sync2_q;

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  logic [7:0] upper_q, upper_d;   // Alarm raise threshold.
  logic [7:0] lower_q, lower_d;   // Alarm clear threshold.
  logic [7:0] ceil_q,  ceil_d;    // Bucket size.
  logic [1:0] decay_q, decay_d;   // Decay selector.
  logic [1:0] mask_q,  mask_d;    // Interrupt enables.

  // Software writes; a zero ceiling or upper value is out of range,
  // so it is forced to one rather than stalling the bucket at zero.
  always_comb begin
    upper_d = upper_q;
    lower_d = lower_q;
    ceil_d  = ceil_q;
    decay_d = decay_q;
    mask_d  = mask_q;
    if (we_i) begin
      case (addr_i)
        lbam_pkg::ADDR_UPPER: upper_d = (wdata_i == 8'h00) ? 8'h01 : wdata_i;
        lbam_pkg::ADDR_LOWER: lower_d = wdata_i;
        lbam_pkg::ADDR_CEIL:  ceil_d  = (wdata_i == 8'h00) ? 8'h01 : wdata_i;
        lbam_pkg::ADDR_DECAY: decay_d = wdata_i[1:0];
        lbam_pkg::ADDR_MASK:  mask_d  = wdata_i[1:0];
        default: begin
          upper_d = upper_q;
        end
      endcase
    end
  end

  // Register configuration.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      upper_q <= lbam_pkg::RST_UPPER;
      lower_q <= lbam_pkg::RST_LOWER;
      ceil_q  <= lbam_pkg::RST_CEIL;
      decay_q <= lbam_pkg::RST_DECAY;
      mask_q  <= lbam_pkg::RST_MASK;
    end else begin
      upper_q <= upper_d;
      lower_q <= lower_d;
      ceil_q  <= ceil_d;
      decay_q <= decay_d;
      mask_q  <= mask_d;
    end
  end

  // ---------------------------------------------------------------
  // Bucket accumulator and alarm
  // ---------------------------------------------------------------
  logic [7:0] acc_q, acc_d;       // Bucket fill level.
  logic [2:0] dcnt_q, dcnt_d;     // Quiet windows since last leak or failed window.
  logic       alarm_q, alarm_d;   // Inactivity alarm.
  logic       raise_ev;           // Alarm rising event.
  logic       clear_ev;           // Alarm falling event.

  // Decay period in windows minus one: 0, 1, 3 or 7.
  function automatic logic [2:0] decay_last(input logic [1:0] sel);
    decay_last = 3'((4'h1 << sel) - 4'h1);
  endfunction

  // One update per window boundary.
  always_comb begin
    acc_d  = acc_q;
    dcnt_d = dcnt_q;
    if (tick) begin
      if (win_fail) begin
        dcnt_d = 3'h0;
        if (acc_q < ceil_q) begin
          acc_d = acc_q + 8'h1;
        end else begin
          acc_d = ceil_q;
        end
      end else if (dcnt_q >= decay_last(decay_q)) begin
        dcnt_d = 3'h0;
        if (acc_q != 8'h0) begin
          acc_d = acc_q - 8'h1;
        end
      end else begin
        dcnt_d = dcnt_q + 3'h1;
      end
      // A ceiling lowered below the count pulls the count down too.
      if (acc_d > ceil_q) begin
        acc_d = ceil_q;
      end
    end
  end

  // Alarm follows the new count; clearing also needs the count below upper, so an upper
  // threshold at or below the lower one keeps the alarm high until the count falls below upper.
  always_comb begin
    alarm_d = alarm_q;
    if (tick) begin
      if (!alarm_q && acc_d >= upper_q) begin
        alarm_d = 1'b1;
      end else if (alarm_q && acc_d <= lower_q && acc_d < upper_q) begin
        alarm_d = 1'b0;
      end
    end
  end

  assign raise_ev = !alarm_q && alarm_d;
  assign clear_ev = alarm_q && !alarm_d;

  // Register bucket state.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      acc_q   <= 8'h00;
      dcnt_q  <= 3'h0;
      alarm_q <= 1'b0;
    end else begin
      acc_q   <= acc_d;
      dcnt_q  <= dcnt_d;
      alarm_q <= alarm_d;
    end
  end

  // ---------------------------------------------------------------
  // Interrupt status
  // ---------------------------------------------------------------
  logic [1:0] stat_q, stat_d;     // Sticky raise and clear events.
  logic [1:0] ev;

  assign ev = {clear_ev, raise_ev};

  // Write one to clear; a new event in the same cycle wins.
  always_comb begin
    stat_d = stat_q;
    if (we_i && addr_i == lbam_pkg::ADDR_STAT) begin
      stat_d = stat_q & ~wdata_i[1:0];
    end
    stat_d = stat_d | ev;
  end

  // Register status.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      stat_q <= 2'h0;
    end else begin
      stat_q <= stat_d;
    end
  end

  assign irq_o = |(stat_q & mask_q);

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  logic [7:0] rdata_q, rdata_d;

  // Unmapped addresses read as zero.
  always_comb begin
    rdata_d = 8'h00;
    if (re_i) begin
      case (addr_i)
        lbam_pkg::ADDR_UPPER: rdata_d = upper_q;
        lbam_pkg::ADDR_LOWER: rdata_d = lower_q;
        lbam_pkg::ADDR_CEIL:  rdata_d = ceil_q;
        lbam_pkg::ADDR_DECAY: rdata_d = {6'h00, decay_q};
        lbam_pkg::ADDR_STAT:  rdata_d = {6'h00, stat_q};
        lbam_pkg::ADDR_MASK:  rdata_d = {6'h00, mask_q};
        lbam_pkg::ADDR_LEVEL: rdata_d = {alarm_q, 7'h00} | {1'b0, acc_q[6:0]};
        default:              rdata_d = 8'h00;
      endcase
    end
  end

  // Read data stand one cycle after the strobe.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign rdata_o = rdata_q;
  assign level_o = acc_q;
  assign alarm_o = alarm_q;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  // Failed window, room left: count grows by exactly one.
  property p_inc;
    @(posedge clk_i) disable iff (rst_i)
      (tick && win_fail && acc_q < ceil_q && !we_i) |=> acc_q == $past(acc_q) + 8'h1;
  endproperty
  a_inc: assert property (p_inc) else $error("bucket did not increment");

  // Outside the window boundary the count is frozen.
  property p_hold;
    @(posedge clk_i) disable iff (rst_i) !tick |=> $stable(acc_q);
  endproperty
  a_hold: assert property (p_hold) else $error("bucket moved off tick");

  // A leak never removes more than one.
  property p_dec;
    @(posedge clk_i) disable iff (rst_i)
      (tick && !win_fail && acc_q <= ceil_q)
      |=> (9'(acc_q) + 9'h001) >= 9'($past(acc_q)); // Nine bits so a count of 255 plus one cannot wrap.
  endproperty
  a_dec: assert property (p_dec) else $error("bucket leaked too fast");

  // At rate one, a quiet window with a nonzero count leaks.
  property p_leak1;
    @(posedge clk_i) disable iff (rst_i)
      (tick && !win_fail && decay_q == 2'h0 && acc_q != 8'h0 && acc_q <= ceil_q)
      |=> acc_q == $past(acc_q) - 8'h1;
  endproperty
  a_leak1: assert property (p_leak1) else $error("no leak at rate one");

  // Count never above ceiling after an update.
  property p_ceil;
    @(posedge clk_i) disable iff (rst_i) $past(tick) |-> acc_q <= $past(ceil_q);
  endproperty
  a_ceil: assert property (p_ceil) else $error("bucket above ceiling");

  // Alarm raised when count reaches the upper threshold.
  property p_raise;
    @(posedge clk_i) disable iff (rst_i)
      $rose(alarm_q) |-> $past(tick) && acc_q >= $past(upper_q);
  endproperty
  a_raise: assert property (p_raise) else $error("alarm raised early");

  // Alarm cleared only at or below the lower threshold.
  property p_clear;
    @(posedge clk_i) disable iff (rst_i)
      $fell(alarm_q) |-> $past(tick) && acc_q <= $past(lower_q);
  endproperty
  a_clear: assert property (p_clear) else $error("alarm cleared early");

  // Raise event sets status and reaches irq when enabled.
  sequence s_raise;
    raise_ev && mask_q[lbam_pkg::STAT_RAISE] && !we_i;
  endsequence
  property p_irq;
    @(posedge clk_i) disable iff (rst_i) s_raise |=> irq_o;
  endproperty
  a_irq: assert property (p_irq) else $error("irq missing on raise");

endmodule // lbam_monitor

/* File: src/lbam_pkg.sv */
// Purpose: Shared constants for the leaky bucket activity monitor.
// Assumes: 25 MHz core clock, byte-wide register port.
// Notes:   Offsets and reset values live here only.
package lbam_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  // Evaluation cycle length in milliseconds.
  localparam int unsigned EVAL_PERIOD_MS = 128;
  // Core clock rate in hertz.
  localparam int unsigned CLK_HZ = 25000000;
  // Cycles per evaluation window.
  localparam int unsigned EVAL_CYCLES = (CLK_HZ / 1000) * EVAL_PERIOD_MS;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  // Byte-wide register addresses.
  localparam logic [7:0] ADDR_UPPER = 8'h58;
  localparam logic [7:0] ADDR_LOWER = 8'h59;
  localparam logic [7:0] ADDR_CEIL  = 8'h5A;
  localparam logic [7:0] ADDR_DECAY = 8'h5B;
  localparam logic [7:0] ADDR_STAT  = 8'h60;
  localparam logic [7:0] ADDR_MASK  = 8'h61;
  localparam logic [7:0] ADDR_LEVEL = 8'h62;
  // Reset values.
  localparam logic [7:0] RST_UPPER = 8'h06;
  localparam logic [7:0] RST_LOWER = 8'h04;
  localparam logic [7:0] RST_CEIL  = 8'h08;
  localparam logic [1:0] RST_DECAY = 2'h1;
  localparam logic [1:0] RST_MASK  = 2'h0;
  // Status bit positions.
  localparam int unsigned STAT_RAISE = 0;
  localparam int unsigned STAT_CLEAR = 1;

endpackage : lbam_pkg

/* File: src/lbam_tick.sv */
// Purpose: Free-running evaluation period tick generator.
// Assumes: Single clock domain.
// Notes:   Emits a one-cycle pulse every PERIOD clocks.
`timescale 1ns/1ns
module lbam_tick #(
  parameter int unsigned PERIOD = lbam_pkg::EVAL_CYCLES
) (
  // Clock and reset.
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Tick output.
  output logic      tick_o
);

  // Down counter; 22 bits covers the full 128 ms window.
  logic [21:0] cnt_q;
  logic [21:0] cnt_d;

  // Reload at zero so the period is exact.
  always_comb begin
    if (cnt_q == 22'h0) begin
      cnt_d = 22'(PERIOD - 1);
    end else begin
      cnt_d = cnt_q - 22'h1;
    end
  end

  // Register the count.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q <= 22'h0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // Pulse once per window.
  assign tick_o = (cnt_q == 22'h1);

endmodule // lbam_tick
